/* File: rtl/ewsf_framer.sv */
// event word stream framer: time word per cycle, then tagged event words
// assumes events arrive with valid/ready and cycle start as a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module ewsf_framer
    import ewsf_pkg::*;
#(
    parameter int BIT_DIV = 2
) (
    // clock and reset
    input  wire logic                ref_clk_i,
    input  wire logic                rst_n_i,
    // thresholds
    input  wire logic [ENERGY_W-1:0] lo_thr_i,
    input  wire logic [ENERGY_W-1:0] hi_thr_i,
    // readout cycle start and time
    input  wire logic                cycle_start_i,
    input  wire logic [TIME_W-1:0]   time_i,
    // event input
    input  wire logic                ev_valid_i,
    input  wire ewsf_event_s         ev_i,
    output logic                     ev_ready_o,
    // serial line
    output logic                     sdata_o,
    output logic                     svalid_o,
    output logic                     time_sent_o
);
    // divider counter is eight bits wide
    if (BIT_DIV < 1 || BIT_DIV > 255) begin : g_bad_div
        $error("BIT_DIV out of range");
    end

    typedef struct packed {
        logic [7:0]        div;
        logic              bit_en;
        logic              tpend;
        logic [TIME_W-1:0] tlat;
        logic              load;
        logic [WORD_W-1:0] word;
        logic              rdy;
        logic              tsent;
        logic              sd;
        logic              sv;
    } ewsf_fr_s;

    ewsf_fr_s s_q, s_d;
    logic     idle;
    logic     sh_data;
    logic     sh_valid;
    logic     in_window;
    ewsf_evword_s evw;
    ewsf_tword_s  tw;

    // energy window on incoming events
    assign in_window = (ev_i.energy >= lo_thr_i) && (ev_i.energy <= hi_thr_i);

    // word images, identical in every mode
    always_comb begin
        evw.flag   = FLAG_EVENT;
        evw.chip   = ev_i.chip;
        evw.col    = ev_i.col;
        evw.row    = ev_i.row;
        evw.energy = ev_i.energy;
        evw.spare  = SPARE_VAL;
        tw.flag    = FLAG_TIME;
        tw.tval    = s_q.tlat;
    end

    // bit divider, time latch, word selection
    always_comb begin
        s_d        = s_q;
        s_d.load   = 1'b0;
        s_d.rdy    = 1'b0;
        s_d.tsent  = 1'b0;
        s_d.bit_en = 1'b0;
        if (s_q.div == 8'(BIT_DIV - 1)) begin
            s_d.div    = '0;
            s_d.bit_en = 1'b1;
        end else begin
            s_d.div = s_q.div + 8'h01;
        end
        if (cycle_start_i) begin
            s_d.tpend = 1'b1;
            s_d.tlat  = time_i;
        end
        if (idle && !s_q.load && !s_q.rdy) begin
            if (s_q.tpend) begin
                s_d.word  = tw;
                s_d.load  = 1'b1;
                s_d.tsent = 1'b1;
                s_d.tpend = cycle_start_i;
            end else if (ev_valid_i && !cycle_start_i) begin
                s_d.rdy = 1'b1;                          // consume event
                if (in_window) begin
                    s_d.word = evw;                      // no header, direct
                    s_d.load = 1'b1;
                end
            end
        end
        s_d.sd = sh_data;
        s_d.sv = sh_valid;
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s_q      <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ewsf_shifter u_shifter (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .load_i    (s_q.load),
        .word_i    (s_q.word),
        .bit_en_i  (s_q.bit_en),
        .sdata_o   (sh_data),
        .svalid_o  (sh_valid),
        .idle_o    (idle)
    );

    assign ev_ready_o  = s_q.rdy;
    assign sdata_o     = s_q.sd;
    assign svalid_o    = s_q.sv;
    assign time_sent_o = s_q.tsent;

    // time word always carries flag one
    a_time_flag : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_q.tsent |-> s_q.word[WORD_W-1] == FLAG_TIME)
        else $error("time word flag not set");
    // event word carries flag zero and zero spare
    a_event_flag : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (s_q.load && !s_q.tsent) |-> (s_q.word[WORD_W-1] == FLAG_EVENT
        && s_q.word[0] == SPARE_VAL))
        else $error("event word flag or spare wrong");
    // chip field placed at bits 30..27
    a_chip_field : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (s_q.load && !s_q.tsent) |-> s_q.word[30:27] == $past(ev_i.chip))
        else $error("chip field misplaced");
    // out-of-window events consumed without a word
    a_energy_win : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (s_q.rdy && !s_q.load) |-> ($past(ev_i.energy) < $past(lo_thr_i)
        || $past(ev_i.energy) > $past(hi_thr_i)))
        else $error("window event dropped");
    // pending time word goes before any event
    a_time_first : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_q.tpend |-> !s_d.rdy)
        else $error("event overtook time word");
endmodule // ewsf_framer
`default_nettype wire

/* File: rtl/ewsf_pkg.sv */
// package for the event word stream framer: word layout, widths, constants
// assumes a single 25 MHz clock and synchronous active-low reset
//
// Notes on behaviour
// - event words go straight onto the serial line, no header word first
// - one time word, 31-bit time plus flag one, opens each 12-chip cycle
// - each event word carries a 4-bit chip field naming its source chip
// - event word: flag 0, chip 4, column 6, row 8, energy 12, spare 1
// - same time and event word layout in every operating mode
// - 12-bit energy forwarded only between adjustable lower and upper limits
package ewsf_pkg;
    localparam int WORD_W     = 32;
    localparam int TIME_W     = 31;
    localparam int CHIP_W     = 4;
    localparam int COL_W      = 6;
    localparam int ROW_W      = 8;
    localparam int ENERGY_W   = 12;
    localparam int CHIPS      = 12;
    localparam int BITCNT_W   = 5;
    localparam logic FLAG_TIME  = 1'b1;
    localparam logic FLAG_EVENT = 1'b0;
    localparam logic SPARE_VAL  = 1'b0;
    localparam logic [ENERGY_W-1:0] LO_THR_RST = 12'h000;
    localparam logic [ENERGY_W-1:0] HI_THR_RST = 12'hfff;

    // one event from the pixel digitiser chain
    typedef struct packed {
        logic [CHIP_W-1:0]   chip;
        logic [COL_W-1:0]    col;
        logic [ROW_W-1:0]    row;
        logic [ENERGY_W-1:0] energy;
    } ewsf_event_s;

    // event word as it goes on the line, msb first
    typedef struct packed {
        logic                flag;
        logic [CHIP_W-1:0]   chip;
        logic [COL_W-1:0]    col;
        logic [ROW_W-1:0]    row;
        logic [ENERGY_W-1:0] energy;
        logic                spare;
    } ewsf_evword_s;

    // time word as it goes on the line
    typedef struct packed {
        logic              flag;
        logic [TIME_W-1:0] tval;
    } ewsf_tword_s;
endpackage

/* File: rtl/ewsf_shifter.sv */
// serialiser of one 32-bit word, msb first, one bit per bit-enable pulse
// assumes the loader only offers a word while idle_o is high
`timescale 1ns/100ps
`default_nettype none
module ewsf_shifter
    import ewsf_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    // word load
    input  wire logic              load_i,
    input  wire logic [WORD_W-1:0] word_i,
    input  wire logic              bit_en_i,
    // serial side
    output logic                   sdata_o,
    output logic                   svalid_o,
    output logic                   idle_o
);
    typedef struct packed {
        logic [WORD_W-1:0]   sh;
        logic [BITCNT_W-1:0] cnt;
        logic                busy;
        logic                dat;
        logic                vld;
        logic                msb;
    } ewsf_sh_s;

    ewsf_sh_s s_q, s_d;

    // shift control: bit leaves on each enable pulse
    always_comb begin
        s_d = s_q;
        if (!s_q.busy && load_i) begin
            s_d.sh   = word_i;
            s_d.cnt  = '0;
            s_d.busy = 1'b1;
            s_d.msb  = word_i[WORD_W-1];             // kept for the first-bit check
        end else if (s_q.busy && bit_en_i) begin
            s_d.dat = s_q.sh[WORD_W-1];
            s_d.vld = 1'b1;
            s_d.sh  = {s_q.sh[WORD_W-2:0], 1'b0};
            s_d.cnt = s_q.cnt + 5'h01;
            if (s_q.cnt == 5'h1f) begin
                s_d.busy = 1'b0;
            end
        end else if (bit_en_i) begin
            s_d.vld = 1'b0;
        end
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sdata_o  = s_q.dat;
    assign svalid_o = s_q.vld;
    assign idle_o   = !s_q.busy && !load_i;

    // first shift of a freshly loaded word
    sequence s_first_shift;
        s_q.busy && bit_en_i && (s_q.cnt == 5'h00);
    endsequence

    // first bit on the line is the msb of the loaded word
    a_msb_first : assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_first_shift |=> (sdata_o == s_q.msb) && svalid_o)
        else $error("first bit is not the msb");
endmodule // ewsf_shifter
`default_nettype wire

/* File: verif/ewsf_rx_model.sv */
// receiving port model: shifts serial words in and queues them whole
// assumes one bit per clock while svalid_i is high (framer BIT_DIV of 1)
`timescale 1ns/100ps
`default_nettype none
module ewsf_rx_model
    import ewsf_pkg::*;
#(
    parameter int PORTS = 2
) (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    // serial side
    input  wire logic sdata_i,
    input  wire logic svalid_i
);
    logic [WORD_W-1:0]   sh_q;
    logic [BITCNT_W-1:0] cnt_q;
    logic [WORD_W-1:0]   words[$];
    // this is the fast science port of a two to five port receiver
    if (PORTS < 2 || PORTS > 5) begin : g_bad_ports
        $error("receiver port count out of range");
    end
    // first bit lands at the top, full words kept unchanged
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cnt_q = '0;
            words.delete();
        end else if (svalid_i) begin
            sh_q = {sh_q[WORD_W-2:0], sdata_i};
            cnt_q = cnt_q + 5'h01;
            // no optional range or field selection: whole words kept
            if (cnt_q == 5'h00) words.push_back(sh_q);
        end
    end
endmodule // ewsf_rx_model
`default_nettype wire

/* File: verif/ewsf_framer_tb.sv */
// self-checking bench for the framer, words judged by the receiver model
// assumes BIT_DIV of 1 so each clock with svalid_o high is one bit
`timescale 1ns/100ps
`default_nettype none
module ewsf_framer_tb;
    import ewsf_pkg::*;
    logic                ref_clk_i, rst_n_i, cycle_start_i, ev_valid_i;
    logic                ev_ready_o, sdata_o, svalid_o, time_sent_o;
    logic [ENERGY_W-1:0] lo_thr_i, hi_thr_i;
    logic [TIME_W-1:0]   time_i;
    ewsf_event_s         ev_i;
    int                  fail_count = 0;
    int                  checked = 0;
    ewsf_framer #(.BIT_DIV(1)) i_ewsf_framer (.ref_clk_i, .rst_n_i, .lo_thr_i,
        .hi_thr_i, .cycle_start_i, .time_i, .ev_valid_i, .ev_i, .ev_ready_o,
        .sdata_o, .svalid_o, .time_sent_o);
    ewsf_rx_model i_ewsf_rx_model (.ref_clk_i, .rst_n_i, .sdata_i(sdata_o),
        .svalid_i(svalid_o));
    // free-running 25 mhz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    task automatic results();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string msg);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask
    // bounded wait for the next received word, then compare
    task automatic chk_word(input logic [WORD_W-1:0] exp);
        int n;
        n = 0;
        while (i_ewsf_rx_model.words.size() == 0 && n < 400) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk_bit(i_ewsf_rx_model.words.size() != 0, 1'b1, "no word arrived");
        if (i_ewsf_rx_model.words.size() == 0) results();
        else chk_bit(i_ewsf_rx_model.words.pop_front() === exp, 1'b1, "word mismatch");
    endtask
    // offer one event, optionally with a cycle start in the same cycle
    task automatic send_ev(input logic st, input logic [CHIP_W+COL_W+ROW_W-1:0] pos,
        input logic [ENERGY_W-1:0] e);
        int n;
        n = 0;
        ev_i = {pos, e};
        ev_valid_i = 1'b1;
        cycle_start_i = st;
        do begin
            @(negedge ref_clk_i);
            cycle_start_i = 1'b0;
            n++;
        end while (ev_ready_o !== 1'b1 && n < 400);
        chk_bit(ev_ready_o, 1'b1, "event not consumed");
        if (ev_ready_o !== 1'b1) results();
        ev_valid_i = 1'b0;
        // let an edge pass so the next offer never rises in this time step
        @(negedge ref_clk_i);
    endtask
    function automatic logic [WORD_W-1:0] ew(input logic [17:0] pos, input logic [11:0] e);
        return {FLAG_EVENT, pos, e, SPARE_VAL};
    endfunction
    task automatic t_time_events();
        int n;
        n = 0;
        time_i = 31'h5234_5678;
        cycle_start_i = 1'b1;
        @(negedge ref_clk_i);
        cycle_start_i = 1'b0;
        while (time_sent_o !== 1'b1 && n < 50) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk_bit(time_sent_o, 1'b1, "time word not loaded");
        if (time_sent_o !== 1'b1) results();
        chk_word({FLAG_TIME, 31'h5234_5678});
        // twelve chips back to back, no header in between
        for (int c = 0; c < CHIPS; c++) send_ev(1'b0, {c[3:0], 6'h2a, 8'hc5}, 12'h800 + c);
        for (int c = 0; c < CHIPS; c++) chk_word(ew({c[3:0], 6'h2a, 8'hc5}, 12'h800 + c));
        $display("test time_events done");
    endtask
    task automatic t_window();
        lo_thr_i = 12'h100;
        hi_thr_i = 12'h200;
        send_ev(1'b0, 18'h1_0203, 12'h0ff);
        send_ev(1'b0, 18'h2_0304, 12'h100);
        send_ev(1'b0, 18'h3_0405, 12'h200);
        send_ev(1'b0, 18'h0_0506, 12'h201);
        chk_word(ew(18'h2_0304, 12'h100));
        chk_word(ew(18'h3_0405, 12'h200));
        repeat (80) @(negedge ref_clk_i);
        chk_bit(i_ewsf_rx_model.words.size() == 0, 1'b1, "dropped event sent");
        lo_thr_i = 12'h000;
        hi_thr_i = 12'hfff;
        $display("test window done");
    endtask
    task automatic t_collide();
        time_i = 31'h0000_0001;
        send_ev(1'b1, 18'h3_ffff, 12'hfff);
        chk_word({FLAG_TIME, 31'h0000_0001});
        chk_word(ew(18'h3_ffff, 12'hfff));
        $display("test collide done");
    endtask
    // reset, then the scenarios in turn
    initial begin
        rst_n_i = 1'b0;
        cycle_start_i = 1'b0;
        ev_valid_i = 1'b0;
        time_i = '0;
        ev_i = '0;
        lo_thr_i = 12'h000;
        hi_thr_i = 12'hfff;
        repeat (10) @(negedge ref_clk_i);
        chk_bit(svalid_o | ev_ready_o | time_sent_o, 1'b0, "outputs busy in reset");
        rst_n_i = 1'b1;
        @(negedge ref_clk_i);
        t_time_events();
        t_window();
        t_collide();
        results();
    end
endmodule // ewsf_framer_tb
`default_nettype wire
